/* tsb_pkg.sv */
/*
  Shared constants and carriers for the trajectory segment buffer controller.
  Assumes a single 50 MHz clock domain and a synchronous active-high reset.
*/
package tsb_pkg;
  localparam logic [15:0] TSB_SEG_CMD_INDEX = 16'h2010;
  localparam int          TSB_DEPTH         = 32;
  localparam int          TSB_MIN_SEGS      = 2;
  localparam int          TSB_HDR_KIND_BIT  = 7;
  localparam int          TSB_CTL_ENABLE    = 4;
  localparam int          TSB_CTL_QSTOP     = 2;
  localparam int          TSB_CTL_HALT      = 8;
  localparam logic [6:0]  TSB_CMD_CLEAR     = 7'h00;
  localparam logic [6:0]  TSB_CMD_POP       = 7'h01;
  localparam logic [6:0]  TSB_CMD_CLR_ERR   = 7'h02;
  localparam logic [6:0]  TSB_CMD_RESET_ID  = 7'h03;
  localparam logic [6:0]  TSB_CMD_NOP       = 7'h04;
  localparam int          TSB_ERR_UNDER     = 0;
  localparam int          TSB_ERR_OVER      = 1;
  localparam int          TSB_ERR_SEQ       = 2;
  localparam int          TSB_ERR_BADCMD    = 3;
  localparam logic [15:0] TSB_ID_RESET      = 16'h0000;
  localparam int          TSB_CLK_HZ        = 50000000;
  localparam int          TSB_MS_NS         = 1000000;
  localparam int          TSB_CLK_NS        = 20;
  localparam int          TSB_MS_CYCLES     = TSB_MS_NS / TSB_CLK_NS;

  typedef struct packed {
    logic [7:0]  header;
    logic [55:0] payload;
  } tsb_seg_s;

  typedef struct packed {
    logic [7:0]  errors;
    logic [15:0] next_id;
    logic [5:0]  count;
    logic        active;
  } tsb_status_s;
endpackage

/* tsb_fifo.sv */
/*
  Segment store with push, pop-oldest and drop-newest operations.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ns
module tsb_fifo
  import tsb_pkg::*;
#(
  parameter int DEPTH = TSB_DEPTH,
  parameter int AW    = 5
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Control.
  input  wire logic        push,
  input  wire tsb_seg_s    push_data,
  input  wire logic        pop_old,
  input  wire logic        drop_new,
  input  wire logic [AW:0] drop_n,
  input  wire logic        flush,
  // State.
  output tsb_seg_s         head,
  output tsb_seg_s         second,
  output logic [AW:0]      count
);
  tsb_seg_s      mem [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] wr_reg;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_reg] <= push_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      rd_reg <= '0;
      wr_reg <= '0;
      count  <= '0;
    end else if (drop_new) begin
      wr_reg <= wr_reg - drop_n[AW-1:0];
      count  <= count - drop_n;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop_old) begin
        rd_reg <= rd_reg + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_old};
    end
  end

  assign head = mem[rd_reg];
  // The entry behind the head is offered too, so the caller never reaches into this store.
  assign second = mem[rd_reg + 1'b1];
endmodule

/* tsb_ctrl.sv */
/*
  Segment command decoder and interpolated move start/stop control.
  Assumes the object write, control word and servo tick are synchronous to ref_clk.
*/
`timescale 1ns/1ns
module tsb_ctrl
  import tsb_pkg::*;
#(
  parameter int DEPTH = TSB_DEPTH,
  parameter int AW    = 5
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Segment command object write.
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [63:0] obj_data,
  // Drive control word and servo timing.
  input  wire logic [15:0] control_word,
  input  wire logic        seg_done,
  // Segment handed to the interpolator.
  output tsb_seg_s         cur_seg,
  output tsb_seg_s         next_seg,
  output logic             move_active,
  output logic             stop_now,
  // Buffer status report.
  output tsb_status_s      status,
  output logic             status_evt
);
  typedef enum {ST_IDLE, ST_RUN, ST_FINISH} tsb_state_e;

  tsb_state_e    state_reg;
  tsb_seg_s      wr_seg;
  tsb_seg_s      head;
  logic [AW:0]   count;
  logic          enable_reg;
  logic [7:0]    err_reg;
  logic [7:0]    err_next;
  logic [15:0]   id_reg;
  logic          is_cmd;
  logic [6:0]    cmd_code;
  logic          wr_hit;
  logic          seg_ok;
  logic          seq_bad;
  logic          overflow;
  logic          do_push;
  logic          do_pop;
  logic          do_flush;
  logic          do_drop;
  logic [AW:0]   drop_n;
  logic          start_move;
  logic          hard_stop;
  logic          underflow;
  logic          zero_time;
  logic          err_evt;
  logic          evt_pend_reg;
  tsb_seg_s      after_head;

  assign wr_seg   = tsb_seg_s'(obj_data);
  assign wr_hit   = obj_wr && (obj_index == TSB_SEG_CMD_INDEX);
  assign is_cmd   = wr_seg.header[TSB_HDR_KIND_BIT];
  assign cmd_code = wr_seg.header[6:0];
  assign seq_bad  = wr_seg.header[2:0] != id_reg[2:0];
  assign overflow = count == (AW+1)'(DEPTH);
  assign seg_ok   = wr_hit && !is_cmd && !err_reg[TSB_ERR_SEQ];
  assign do_push  = seg_ok && !seq_bad && !overflow && !do_pop;

  assign hard_stop = !control_word[TSB_CTL_ENABLE] || !control_word[TSB_CTL_QSTOP]
                     || control_word[TSB_CTL_HALT];
  // rising edge starts, needs two segments
  assign start_move = (state_reg == ST_IDLE) && control_word[TSB_CTL_ENABLE] && !enable_reg
                      && !hard_stop && (count >= (AW+1)'(TSB_MIN_SEGS));
  assign underflow = (state_reg == ST_RUN) && seg_done && (count < (AW+1)'(TSB_MIN_SEGS + 1));
  // format 0 byte 1 time, zero ends
  assign zero_time = next_seg.payload[55:48] == 8'h00;
  assign do_pop    = (state_reg == ST_RUN) && seg_done && !underflow;
  assign do_flush  = wr_hit && is_cmd && (cmd_code == TSB_CMD_CLEAR);
  assign do_drop   = wr_hit && is_cmd && (cmd_code == TSB_CMD_POP) && !do_pop;
  assign drop_n    = ({1'b0, wr_seg.payload[55:48]} > {{(8-AW){1'b0}}, count}) ? count
                     : wr_seg.payload[48 +: AW+1];
  assign err_evt   = underflow || (seg_ok && (seq_bad || overflow))
                     || (wr_hit && is_cmd && (cmd_code > TSB_CMD_NOP));

  tsb_fifo #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .push      (do_push),
    .push_data (wr_seg),
    .pop_old   (do_pop),
    .drop_new  (do_drop),
    .drop_n    (drop_n),
    .flush     (do_flush),
    .head      (head),
    .second    (after_head),
    .count     (count)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Held high in reset so an enable already set at release is not taken for a rising edge.
      enable_reg <= 1'b1;
    end else begin
      enable_reg <= control_word[TSB_CTL_ENABLE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (hard_stop || do_flush || underflow) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_move) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // finish current set point then stop
          if (do_pop && zero_time) begin
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          if (seg_done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    err_next = err_reg;
    if (wr_hit && is_cmd && (cmd_code == TSB_CMD_CLR_ERR)) begin
      err_next = err_reg & ~wr_seg.payload[55:48];
    end
    if (underflow) begin
      err_next[TSB_ERR_UNDER] = 1'b1;
    end
    if (seg_ok && !seq_bad && overflow) begin
      err_next[TSB_ERR_OVER] = 1'b1;
    end
    if (seg_ok && seq_bad) begin
      err_next[TSB_ERR_SEQ] = 1'b1;
    end
    if (wr_hit && is_cmd && (cmd_code > TSB_CMD_NOP)) begin
      err_next[TSB_ERR_BADCMD] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_reg <= 8'h00;
    end else begin
      err_reg <= err_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      id_reg <= TSB_ID_RESET;
    end else if (wr_hit && is_cmd && (cmd_code == TSB_CMD_RESET_ID)) begin
      id_reg <= TSB_ID_RESET;
    end else if (do_push) begin
      id_reg <= id_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_pend_reg <= 1'b0;
      status_evt   <= 1'b0;
      status       <= '0;
    end else begin
      evt_pend_reg <= do_pop || err_evt;
      // The pulse waits one cycle so that it coincides with the refreshed status fields.
      status_evt   <= evt_pend_reg;
      status.next_id <= id_reg;
      status.errors  <= err_reg;
      status.count   <= count;
      status.active  <= state_reg != ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_seg  <= '0;
      next_seg <= '0;
      stop_now <= 1'b0;
    end else begin
      cur_seg  <= head;
      next_seg <= tsb_seg_s'(64'h0);
      stop_now <= (state_reg != ST_IDLE) && (hard_stop || do_flush || underflow);
      if (count > (AW+1)'(1)) begin
        next_seg <= after_head;
      end
    end
  end

  assign move_active = state_reg != ST_IDLE;

  // Assertions.
  seq_reject_a: assert property (@(posedge ref_clk) disable iff (rst)
    err_reg[TSB_ERR_SEQ] && wr_hit && !is_cmd |=> count <= $past(count))
    else $error("segment queued during sequencing error");
  stop_imm_a: assert property (@(posedge ref_clk) disable iff (rst)
    move_active && hard_stop |=> !move_active && stop_now)
    else $error("move not stopped at once");
  start_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    !move_active && !$past(move_active) ##1 move_active |-> $rose(enable_reg))
    else $error("move started without enable edge");
  under_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    underflow |=> err_reg[TSB_ERR_UNDER] && !move_active)
    else $error("underflow not handled");
  cap_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    count <= (AW+1)'(DEPTH))
    else $error("buffer past capacity");
  id_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && is_cmd && cmd_code == TSB_CMD_RESET_ID |=> id_reg == 16'h0000)
    else $error("identifier not reset");
  err_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    err_reg[TSB_ERR_OVER] && !(wr_hit && is_cmd) |=> err_reg[TSB_ERR_OVER])
    else $error("overflow flag lost");
  flush_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_flush |=> count == '0 ##1 !move_active)
    else $error("clear command did not empty buffer");
  report_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_pop |-> ##2 status_evt)
    else $error("no report after consume");
  report_id_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_pop |-> ##2 status.next_id == $past(id_reg))
    else $error("report lacks next identifier");
  err_report_a: assert property (@(posedge ref_clk) disable iff (rst)
    err_evt |-> ##2 status_evt)
    else $error("no report after error");
  pop_newest_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_drop |=> count == $past(count - drop_n))
    else $error("pop removed wrong number");
  pop_keeps_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_drop && move_active && !hard_stop && !seg_done |=> move_active)
    else $error("pop stopped the move");
  pop_saturate_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_drop && (wr_seg.payload[55:48] >= 8'(count)) |=> count == '0)
    else $error("oversized pop left segments");
  mask_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && is_cmd && (cmd_code == TSB_CMD_CLR_ERR) && !err_evt |=> (err_reg & $past(wr_seg.payload[55:48])) == 8'h00)
    else $error("masked error not cleared");
  seq_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    seg_ok && seq_bad |=> err_reg[TSB_ERR_SEQ] && (count <= $past(count)))
    else $error("out of order segment accepted");
  id_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_push |=> id_reg == $past(id_reg) + 16'h0001)
    else $error("identifier did not advance");
  zero_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    do_pop && zero_time && !hard_stop && !do_flush |=> move_active)
    else $error("zero time cut the set point short");
  zero_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_FINISH && seg_done && !hard_stop && !do_flush |=> !move_active)
    else $error("move not ended after zero time");
  min_segs_a: assert property (@(posedge ref_clk) disable iff (rst)
    !move_active ##1 move_active |-> $past(count) >= (AW+1)'(TSB_MIN_SEGS))
    else $error("move started with too few segments");
  bad_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && is_cmd && (cmd_code > TSB_CMD_NOP) |=> err_reg[TSB_ERR_BADCMD])
    else $error("unknown command not flagged");
endmodule

/* tsb_master_model.sv */
/*
  Network master model that writes segment command objects.
  Assumes the bench sequences it and reads the status report itself.
*/
`timescale 1ns/1ns
module tsb_master_model
  import tsb_pkg::*;
(
  // Clock.
  input  wire logic   ref_clk,
  // Object write.
  output logic        obj_wr,
  output logic [15:0] obj_index,
  output logic [63:0] obj_data
);
  initial begin
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_data = 64'h0000000000000000;
  end

  task automatic put(input logic [7:0] hdr, input logic [7:0] arg);
    @(posedge ref_clk);
    #2;
    obj_wr = 1'b1;
    obj_index = TSB_SEG_CMD_INDEX;
    obj_data = {hdr, arg, 48'h123456000100};
    @(posedge ref_clk);
    #2;
    obj_wr = 1'b0;
    // Idle lines are inverted so a stale word can never pass for a fresh one.
    obj_index = ~obj_index;
    obj_data = ~obj_data;
  endtask
endmodule

/* trajectory_segment_buffer_ctrl_tb_top.sv */
/*
  Self-checking bench for the segment command controller.
  Assumes the master model writes objects; the bench drives control word and seg_done.
*/
`timescale 1ns/1ns
module trajectory_segment_buffer_ctrl_tb_top
  import tsb_pkg::*;
;
  typedef struct packed {
    logic [7:0]  hdr;
    logic [7:0]  arg;
    logic [7:0]  cnt;
    logic [7:0]  err;
    logic [15:0] id;
  } tsb_row_s;
  localparam logic [15:0] WAYS [3] = '{16'h0004, 16'h0010, 16'h0114};
  logic        ref_clk, rst, obj_wr, seg_done, move_active, stop_now, status_evt, seen;
  logic [15:0] obj_index, control_word;
  logic [63:0] obj_data;
  tsb_seg_s    cur_seg, next_seg;
  tsb_status_s status;
  tsb_row_s    rows [14];
  int          n_mismatch, checked, sid;

  tsb_ctrl uut (.ref_clk(ref_clk), .rst(rst), .obj_wr(obj_wr), .obj_index(obj_index), .obj_data(obj_data),
    .control_word(control_word), .seg_done(seg_done), .cur_seg(cur_seg), .next_seg(next_seg),
    .move_active(move_active), .stop_now(stop_now), .status(status), .status_evt(status_evt));
  tsb_master_model mst (.ref_clk(ref_clk), .obj_wr(obj_wr), .obj_index(obj_index), .obj_data(obj_data));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Status shows a write one edge after it is taken, so one more edge passes before a check.
  task automatic wr(input logic [7:0] hdr, input logic [7:0] arg);
    mst.put(hdr, arg);
    tick(1);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits a few cycles for a one-cycle pulse: 0 selects the report, 1 the stop.
  task automatic poll(input int which);
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      seen = (which == 0) ? (status_evt === 1'b1) : (stop_now === 1'b1);
      if (!seen) tick(1);
    end
    tick(1);
  endtask
  task automatic fill(input int n, input int zero_at);
    for (int i = 0; i < n; i++) begin
      mst.put({5'h00, sid[2:0]}, (i == zero_at) ? 8'h00 : 8'h0A);
      sid++;
    end
    tick(1);
  endtask
  task automatic fresh();
    control_word = 16'h0004;
    mst.put(8'h80, 8'h00);
    mst.put(8'h83, 8'h00);
    sid = 0;
  endtask
  task automatic start();
    control_word = 16'h0014;
    tick(1);
  endtask
  task automatic done();
    seg_done = 1'b1;
    tick(1);
    seg_done = 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // The whole sequence needs well under a thousand cycles; this is ten times that.
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    seg_done = 1'b0;
    control_word = 16'h0004;
    n_mismatch = 0;
    checked = 0;
    sid = 0;
    rows = '{'{8'h00, 8'h0A, 8'h01, 8'h00, 16'h0001}, '{8'h01, 8'h0A, 8'h02, 8'h00, 16'h0002},
      '{8'h03, 8'h0A, 8'h02, 8'h04, 16'h0002}, '{8'h02, 8'h0A, 8'h02, 8'h04, 16'h0002},
      '{8'h82, 8'h04, 8'h02, 8'h00, 16'h0002}, '{8'h2A, 8'h0A, 8'h03, 8'h00, 16'h0003},
      '{8'h84, 8'h00, 8'h03, 8'h00, 16'h0003}, '{8'h85, 8'h00, 8'h03, 8'h08, 16'h0003},
      '{8'h82, 8'h08, 8'h03, 8'h00, 16'h0003}, '{8'h81, 8'h01, 8'h02, 8'h00, 16'hFFFF},
      '{8'h83, 8'h00, 8'h02, 8'h00, 16'h0000}, '{8'h81, 8'h09, 8'h00, 8'h00, 16'hFFFF},
      '{8'h00, 8'h0A, 8'h01, 8'h00, 16'h0001}, '{8'h80, 8'h00, 8'h00, 8'h00, 16'hFFFF}};
    tick(6);
    rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].hdr, rows[i].arg);
      chk("count", 16'(rows[i].cnt), 16'(status.count));
      chk("errors", 16'(rows[i].err), 16'(status.errors));
      if (rows[i].id !== 16'hFFFF) chk("next_id", rows[i].id, status.next_id);
    end
    $display("table test done");
    fresh();
    fill(1, -1);
    start();
    chk("active_one_seg", 16'h0000, 16'(move_active));
    control_word = 16'h0004;
    fill(3, -1);
    start();
    chk("active", 16'h0001, 16'(move_active));
    done();
    poll(0);
    chk("report_seen", 16'h0001, 16'(seen));
    chk("count_consumed", 16'h0003, 16'(status.count));
    chk("status_active", 16'h0001, 16'(status.active));
    chk("next_id_report", 16'h0004, status.next_id);
    done();
    poll(0);
    done();
    poll(0);
    chk("report_on_error", 16'h0001, 16'(seen));
    chk("active_underflow", 16'h0000, 16'(move_active));
    chk("underflow_flag", 16'h0001, 16'(status.errors[TSB_ERR_UNDER]));
    wr(8'h84, 8'h00);
    chk("underflow_held", 16'h0001, 16'(status.errors[TSB_ERR_UNDER]));
    wr(8'h82, 8'h01);
    chk("underflow_cleared", 16'h0000, 16'(status.errors));
    $display("consume test done");
    for (int k = 0; k < 3; k++) begin
      fresh();
      fill(4, -1);
      start();
      chk("active", 16'h0001, 16'(move_active));
      control_word = WAYS[k];
      poll(1);
      chk("stop_pulse", 16'h0001, 16'(seen));
      chk("active_stopped", 16'h0000, 16'(move_active));
    end
    $display("stop test done");
    fresh();
    fill(6, 1);
    start();
    chk("cur_seg", 16'h000A, cur_seg[63:48]);
    chk("next_seg", 16'h0100, next_seg[63:48]);
    done();
    tick(1);
    chk("active_before_end", 16'h0001, 16'(move_active));
    done();
    tick(1);
    if (move_active === 1'b1) done();
    tick(1);
    chk("active_after_end", 16'h0000, 16'(move_active));
    chk("errors_after_end", 16'h0000, 16'(status.errors));
    $display("zero time test done");
    fresh();
    fill(5, -1);
    start();
    wr(8'h81, 8'h01);
    chk("active_after_pop", 16'h0001, 16'(move_active));
    chk("count_after_pop", 16'h0004, 16'(status.count));
    wr(8'h80, 8'h00);
    chk("active_after_clear", 16'h0000, 16'(move_active));
    chk("count_after_clear", 16'h0000, 16'(status.count));
    $display("pop and clear test done");
    fresh();
    fill(32, -1);
    chk("count_full", 16'h0020, 16'(status.count));
    fill(1, -1);
    chk("overflow_flag", 16'h0002, 16'(status.errors));
    chk("count_full", 16'h0020, 16'(status.count));
    $display("overflow test done");
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    tick(1);
    chk("status_reset", 16'h0000, 16'({status.count, status.errors, status.active}));
    chk("next_id_reset", TSB_ID_RESET, status.next_id);
    chk("active_reset", 16'h0000, 16'(move_active));
    $display("reset test done");
    stop_test();
  end
endmodule
